// ---- include/tofc_pkg.sv ----
package tofc_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int SYS_CLK_MHZ = 25;
	localparam int SCL_PERIOD_NS = 1000;
	// quarter of a bit slot, rounded up so the bit rate never exceeds the ceiling
	localparam int QTR_CYC = (SCL_PERIOD_NS * SYS_CLK_MHZ + 3999) / 4000;
	localparam logic [2:0] QTR_LAST = 3'(QTR_CYC - 1);
	localparam int BOOT_TIME_NS = 1200000;
	localparam int BOOT_CYC = (BOOT_TIME_NS * SYS_CLK_MHZ + 999) / 1000;

	// ----------------------------------------------------------------
	// sensor side
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_WR = 8'h52;
	localparam logic [7:0] ADDR_RD = 8'h53;
	localparam logic [15:0] IDX_PART_IDENTIFIER = 16'h010f;
	localparam logic [15:0] IDX_PART_KIND_CODE = 16'h0110;

	// ----------------------------------------------------------------
	// own registers, byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_RDATA = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam int CTRL_PWR = 0;
	localparam int CTRL_PIN_MODE = 1;
	localparam int CMD_IDX_LSB = 0;
	localparam int CMD_LEN_LSB = 16;
	localparam int CMD_READ = 19;
	localparam int CMD_GO = 31;
	localparam int STAT_BUSY = 0;
	localparam int STAT_BOOTED = 1;
	localparam int STAT_NACK = 2;
	localparam int STAT_DONE = 3;
	localparam int STAT_REFUSED = 4;
	localparam int STAT_INT = 5;
	localparam int STAT_SCL = 6;
	localparam int STAT_SDA = 7;
	localparam logic [31:0] WORD_RST = 32'h0;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_ADDR = 3'b010,
		ST_IDXH = 3'b011,
		ST_IDXL = 3'b100,
		ST_WDATA = 3'b101,
		ST_RDATA = 3'b110,
		ST_STOP = 3'b111
	} tofc_state_t;

	typedef struct packed {
		logic scl_out;
		logic scl_oe;
		logic sda_out;
		logic sda_oe;
		logic shutdown_n_pin;
	} tofc_pins_t;

	typedef struct packed {
		tofc_state_t fsm;
		logic [1:0] q;
		logic [2:0] tick;
		logic [3:0] bitn;
		logic [7:0] sh;
		logic smp;
		logic rw;
		logic rd_phase;
		logic [2:0] len;
		logic [2:0] left;
		logic [15:0] idx;
		logic [31:0] wsh;
		logic [31:0] rdata;
		logic nack;
		logic done;
		logic refused;
		logic scl_oe;
		logic sda_oe;
		logic pwr;
		logic pin_mode;
		logic [31:0] wdata;
		logic booted;
		logic [19:0] boot_cnt;
		logic dp_wr;
		logic [7:0] dp_addr;
		logic [31:0] hrdata;
	} tofc_core_t;
endpackage

// ---- rtl/tofc_host.sv ----
// Function
// - address byte lsb picks direction: 0x53 reads, 0x52 writes
// - write message: two index bytes follow, high byte first
// - sample sda on rising scl; sda steady while scl high
// - every byte gets one ack from its receiver
// - only the controller ends: stop, or nack after last read byte
// - 8, 16 or 32 bit access, msb at lowest index
// - host reads result after interrupt, then clears it
// - boot takes at most 1.2 ms; host waits that long
// - host raises shutdown only with supply on, always drives it
// - controller makes scl, starts transfers, at most 1 Mbit/s
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module tofc_host #(
	parameter int BOOT_CYCLES = tofc_pkg::BOOT_CYC
) (
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic [31:0] o_hrdata,
	input wire logic i_scl_in,
	input wire logic i_sda_in,
	input wire logic i_interrupt_out_pin_n,
	output var tofc_pkg::tofc_pins_t o_pins
);
	import tofc_pkg::*;

	tofc_core_t st;
	tofc_core_t next_st;
	logic [2:0] pins_sync;
	logic scl_in;
	logic sda_in;
	logic int_n;
	logic qend;
	logic addr_ph;

	// ----------------------------------------------------------------
	// pin inputs
	// ----------------------------------------------------------------
	tofc_sync #(.W(3)) u_sync (
		.i_sys_clk(i_sys_clk),
		.i_srst(i_srst),
		.i_async({i_scl_in, i_sda_in, i_interrupt_out_pin_n}),
		.o_sync(pins_sync)
	);
	assign scl_in = pins_sync[2];
	assign sda_in = pins_sync[1];
	assign int_n = pins_sync[0];

	assign qend = (st.tick == QTR_LAST);
	// hsize ignored: only whole words are supported
	assign addr_ph = i_hsel && i_htrans[1] && i_hready;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [31:0] stat;
		logic [2:0] len;
		stat = WORD_RST;
		len = i_hwdata[CMD_LEN_LSB +: 3];
		next_st = st;
		if (len > 3'd4) begin
			len = 3'd4;
		end
		stat[STAT_BUSY] = (st.fsm != ST_IDLE);
		stat[STAT_BOOTED] = st.booted;
		stat[STAT_NACK] = st.nack;
		stat[STAT_DONE] = st.done;
		stat[STAT_REFUSED] = st.refused;
		stat[STAT_INT] = st.pin_mode && !int_n;
		stat[STAT_SCL] = scl_in;
		stat[STAT_SDA] = sda_in;

		// bus slave, zero wait states
		next_st.dp_wr = addr_ph && i_hwrite;
		next_st.dp_addr = i_haddr[7:0];
		if (addr_ph && !i_hwrite) begin
			case (i_haddr[7:0])
				REG_CTRL: next_st.hrdata = {30'h0, st.pin_mode, st.pwr};
				REG_CMD: next_st.hrdata = {12'h0, st.rw, st.len, st.idx};
				REG_WDATA: next_st.hrdata = st.wdata;
				REG_RDATA: next_st.hrdata = st.rdata;
				REG_STATUS: next_st.hrdata = stat;
				default: next_st.hrdata = WORD_RST;
			endcase
		end
		if (st.dp_wr) begin
			case (st.dp_addr)
				REG_CTRL: begin
					next_st.pwr = i_hwdata[CTRL_PWR];
					next_st.pin_mode = i_hwdata[CTRL_PIN_MODE];
				end
				REG_WDATA: next_st.wdata = i_hwdata;
				REG_CMD: begin
					if (i_hwdata[CMD_GO] && st.booted && st.fsm == ST_IDLE) begin
						next_st.fsm = ST_START;
						next_st.q = 2'd0;
						next_st.tick = 3'd0;
						next_st.rw = i_hwdata[CMD_READ];
						next_st.rd_phase = 1'b0;
						next_st.idx = i_hwdata[CMD_IDX_LSB +: 16];
						next_st.len = len;
						// an empty read still fetches one byte; an empty write only sets the index
						next_st.left = (i_hwdata[CMD_READ] && len == 3'd0) ? 3'd1 : len;
						next_st.wsh = st.wdata << {3'd4 - len, 3'b000};
						next_st.rdata = WORD_RST;
						next_st.nack = 1'b0;
						next_st.done = 1'b0;
						next_st.refused = 1'b0;
					end else if (i_hwdata[CMD_GO]) begin
						next_st.refused = 1'b1;
					end
				end
				default: ;
			endcase
		end

		// boot wait after the shutdown pin rises
		if (!st.pwr) begin
			next_st.boot_cnt = 20'h0;
			next_st.booted = 1'b0;
		end else if (!st.booted) begin
			if (st.boot_cnt == 20'(BOOT_CYCLES - 1)) begin
				next_st.booted = 1'b1;
			end else begin
				next_st.boot_cnt = st.boot_cnt + 20'h1;
			end
		end

		// ------------------------------------------------------------
		// bit engine: four quarters per slot, scl high in the last two of a data slot
		// ------------------------------------------------------------
		if (st.fsm != ST_IDLE) begin
			next_st.tick = st.tick + 3'd1;
			if (qend) begin
				next_st.tick = 3'd0;
				next_st.q = st.q + 2'd1;
				if (st.q == 2'd2) begin
					next_st.smp = sda_in;
				end
				if (st.q == 2'd3) begin
					next_st.bitn = st.bitn + 4'd1;
					next_st.sh = {st.sh[6:0], st.smp};
					case (st.fsm)
						ST_START: begin
							next_st.fsm = ST_ADDR;
							next_st.bitn = 4'd0;
							next_st.sh = st.rd_phase ? ADDR_RD : ADDR_WR;
						end
						ST_STOP: begin
							next_st.fsm = ST_IDLE;
							next_st.done = 1'b1;
						end
						default: begin
							if (st.bitn == 4'd8) begin
								next_st.bitn = 4'd0;
								if (st.fsm == ST_RDATA) begin
									next_st.rdata = {st.rdata[23:0], st.sh};
									next_st.left = st.left - 3'd1;
									next_st.fsm = (st.left == 3'd1) ? ST_STOP : ST_RDATA;
								end else if (st.smp) begin
									// no ack from the sensor: give up with a stop
									next_st.nack = 1'b1;
									next_st.fsm = ST_STOP;
								end else begin
									case (st.fsm)
										ST_ADDR: begin
											if (st.rd_phase) begin
												next_st.fsm = ST_RDATA;
											end else begin
												next_st.fsm = ST_IDXH;
												next_st.sh = st.idx[15:8];
											end
										end
										ST_IDXH: begin
											next_st.fsm = ST_IDXL;
											next_st.sh = st.idx[7:0];
										end
										ST_IDXL: begin
											if (st.rw) begin
												// repeated start turns the bus round for the read
												next_st.fsm = ST_START;
												next_st.rd_phase = 1'b1;
											end else if (st.left != 3'd0) begin
												next_st.fsm = ST_WDATA;
												next_st.sh = st.wsh[31:24];
												next_st.wsh = {st.wsh[23:0], 8'h00};
											end else begin
												next_st.fsm = ST_STOP;
											end
										end
										ST_WDATA: begin
											next_st.left = st.left - 3'd1;
											if (st.left == 3'd1) begin
												next_st.fsm = ST_STOP;
											end else begin
												next_st.sh = st.wsh[31:24];
												next_st.wsh = {st.wsh[23:0], 8'h00};
											end
										end
										default: next_st.fsm = ST_STOP;
									endcase
								end
							end
						end
					endcase
				end
			end
		end

		// shutdown pin low: sensor is asleep, so drop any transfer at once
		if (!next_st.pwr) begin
			next_st.fsm = ST_IDLE;
			next_st.q = 2'd0;
			next_st.tick = 3'd0;
		end

		// line shapes from the coming slot, so pins leave flip-flops
		case (next_st.fsm)
			ST_IDLE: begin
				next_st.scl_oe = 1'b0;
				next_st.sda_oe = 1'b0;
			end
			ST_START: begin
				next_st.scl_oe = (next_st.q == 2'd0);
				next_st.sda_oe = next_st.q[1];
			end
			ST_STOP: begin
				next_st.scl_oe = (next_st.q == 2'd0);
				next_st.sda_oe = !next_st.q[1];
			end
			ST_RDATA: begin
				next_st.scl_oe = !next_st.q[1];
				next_st.sda_oe = (next_st.bitn == 4'd8) && (next_st.left != 3'd1);
			end
			default: begin
				next_st.scl_oe = !next_st.q[1];
				next_st.sda_oe = (next_st.bitn != 4'd8) && !next_st.sh[7];
			end
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_hrdata = st.hrdata;
	assign o_pins.scl_out = 1'b0;
	assign o_pins.scl_oe = st.scl_oe;
	assign o_pins.sda_out = 1'b0;
	assign o_pins.sda_oe = st.sda_oe;
	assign o_pins.shutdown_n_pin = st.pwr;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [19:0] pwr_age;
	always_ff @(posedge i_sys_clk) begin
		if (i_srst || !st.pwr) begin
			pwr_age <= 20'h0;
		end else if (pwr_age != 20'hfffff) begin
			pwr_age <= pwr_age + 20'h1;
		end
	end

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_srst);

	scl_low_time_a: assert property (disable iff (i_srst || !st.pwr) $rose(st.scl_oe) |=> st.scl_oe [*6])
		else $error("scl low phase too short");
	scl_high_time_a: assert property ($fell(st.scl_oe) |=> !st.scl_oe [*8])
		else $error("scl high phase too short");
	sda_steady_a: assert property (disable iff (i_srst || !st.pwr)
		(!st.scl_oe && !$past(st.scl_oe) && st.fsm != ST_START && st.fsm != ST_STOP) |-> $stable(st.sda_oe))
		else $error("sda moved while scl high");
	addr_dir_a: assert property ((st.fsm == ST_ADDR && $past(st.fsm) == ST_START)
		|-> st.sh == (st.rd_phase ? ADDR_RD : ADDR_WR))
		else $error("wrong address byte");
	index_high_a: assert property ((st.fsm == ST_IDXH && $past(st.fsm) == ST_ADDR) |-> st.sh == st.idx[15:8])
		else $error("index high byte not sent first");
	read_ack_a: assert property ((st.fsm == ST_RDATA && st.bitn == 4'd8 && st.q == 2'd2)
		|-> st.sda_oe == (st.left != 3'd1))
		else $error("wrong ack on read byte");
	last_nack_stop_a: assert property ((st.fsm == ST_RDATA && st.bitn == 4'd8 && st.left == 3'd1 && st.q == 2'd2)
		|-> !st.sda_oe ##[1:14] st.fsm == ST_STOP)
		else $error("last read byte not ended by stop");
	read_msb_first_a: assert property ((st.fsm == ST_RDATA && st.bitn == 4'd8 && st.q == 2'd3 && qend)
		|=> st.rdata == {$past(st.rdata[23:0]), $past(st.sh)})
		else $error("read bytes packed in wrong order");
	boot_wait_a: assert property (st.fsm != ST_IDLE |-> pwr_age >= 20'(BOOT_CYCLES))
		else $error("bus used before boot time");
	power_quiet_a: assert property ($fell(st.pwr) |-> st.fsm == ST_IDLE && !o_pins.scl_oe && !o_pins.sda_oe)
		else $error("bus active with shutdown pin low");

	cover property ($rose(st.done) && !st.rw && !st.nack);
	cover property ($rose(st.done) && st.rw && st.len == 3'd4);
	cover property (st.fsm == ST_START && st.rd_phase);
	cover property ($rose(st.nack));
endmodule
`default_nettype wire

// ---- rtl/tofc_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module tofc_sync #(
	parameter int W = 1
) (
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} tofc_sync_t;

	tofc_sync_t st;
	tofc_sync_t next_st;

	// idle bus lines and the released interrupt pin all sit high
	always_comb begin
		next_st = st;
		next_st.s1 = i_async;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < W; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.q[i] = st.s3[i];
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			st <= '1;
		end else begin
			st <= next_st;
		end
	end

	assign o_sync = st.q;
endmodule
`default_nettype wire

// ---- tb/tof_sensor_i2c_control_port_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module tof_sensor_i2c_control_port_bench;
	import tofc_pkg::*;
	localparam int BOOT_N = 50;
	localparam logic [7:0] PART_ID = 8'h5a; // arbitrary value
	localparam logic [7:0] KIND_ID = 8'h3c; // arbitrary value
	localparam logic [15:0] RES_IDX = 16'h0089;
	localparam logic [15:0] CLR_IDX = 16'h0086;
	logic i_sys_clk = 1'b0, i_srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, want = 1'b0, dp_chk = 1'b0;
	logic deaf = 1'b0, fire = 1'b0, hready, hresp, sda_pull, int_n;
	logic [1:0] htrans = 2'b00;
	logic [7:0] haddr = 8'h0, code = 8'h0;
	logic [31:0] hwdata = 32'h0, hrdata, r, d, m;
	logic [15:0] ix;
	logic [2:0] n;
	logic [63:0] exp_q[$];
	int err_total = 0, checks = 0, cyc = 0;
	tofc_pins_t pins;
	wire scl_w, sda_w;
	// pull-ups on both lines, any party pulling low wins
	assign scl_w = pins.scl_oe ? 1'b0 : 1'b1;
	assign sda_w = (pins.sda_oe | sda_pull) ? 1'b0 : 1'b1;
	always #20 i_sys_clk = ~i_sys_clk;
	tofc_host #(.BOOT_CYCLES(BOOT_N)) tofc_host_i (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_hsel(hsel),
		.i_haddr({24'h0, haddr}), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata),
		.i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata), .i_scl_in(scl_w),
		.i_sda_in(sda_w), .i_interrupt_out_pin_n(int_n), .o_pins(pins));
	tofc_sensor_model #(.PART_ID(PART_ID), .KIND_ID(KIND_ID), .RES_IDX(RES_IDX), .CLR_IDX(CLR_IDX),
		.BOOT_NS(BOOT_N * 40.0))
		tofc_sensor_model_i (.i_scl(scl_w), .i_sda(sda_w), .i_shutdown_n_pin(pins.shutdown_n_pin),
		.i_deaf(deaf), .i_fire(fire), .i_code(code), .o_sda_pull(sda_pull), .o_int_n(int_n));
	// ----
	// checking and bus tasks
	// ----
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp_v);
		checks++;
		if (seen !== exp_v) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp_v);
		end
	endtask
	task automatic complete_run();
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// notes are popped only for reads flagged when their address phase went out
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		dp_chk <= hsel & htrans[1] & hready & !hwrite & want;
		if (dp_chk) begin
			chk(hrdata & exp_q[0][63:32], exp_q[0][31:0]);
			chk(32'(hresp), 32'h0);
			void'(exp_q.pop_front());
		end
		if (cyc == 90000) begin
			err_total++;
			complete_run();
		end
	end
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] dw, input logic c);
		@(posedge i_sys_clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		want <= c;
		do @(posedge i_sys_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		want <= 1'b0;
		hwdata <= dw;
		do @(posedge i_sys_clk); while (hready !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] dw);
		ahb(1'b1, a, dw, 1'b0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] v);
		exp_q.push_back({mk, v});
		ahb(1'b0, a, 32'h0, 1'b1);
	endtask
	task automatic go(input logic rn, input logic [2:0] len, input logic [15:0] a, input logic [31:0] dw);
		wr(REG_WDATA, dw);
		wr(REG_CMD, {1'b1, 11'h0, rn, len, a});
		do ahb(1'b0, REG_STATUS, 32'h0, 1'b0); while (r[STAT_BUSY] !== 1'b0);
	endtask
	initial begin
		void'($urandom(46925));
		repeat (6) @(posedge i_sys_clk);
		i_srst <= 1'b0;
		rd(REG_STATUS, 32'hc3, 32'hc0);
		chk(32'(pins.shutdown_n_pin), 32'h0);
		go(1'b1, 3'h1, 16'h010f, 32'h0);
		rd(REG_STATUS, 32'h13, 32'h10);
		wr(REG_CTRL, 32'h3);
		rd(REG_STATUS, 32'h02, 32'h0);
		chk(32'(pins.shutdown_n_pin), 32'h1);
		repeat (BOOT_N + 4) @(posedge i_sys_clk);
		go(1'b1, 3'h1, 16'h010f, 32'h0);
		rd(REG_STATUS, 32'h1f, 32'h0a);
		rd(REG_RDATA, 32'hff, {24'h0, PART_ID});
		go(1'b1, 3'h2, 16'h010f, 32'h0);
		rd(REG_RDATA, 32'hffff, {16'h0, PART_ID, KIND_ID});
		for (int k = 0; k < 3; k++) begin
			n = (k == 2) ? 3'h4 : 3'(k + 1);
			ix = 16'h0200 + 16'($urandom_range(255));
			d = $urandom;
			m = (n == 3'h4) ? 32'hffffffff : (32'h1 << (8 * n)) - 32'h1;
			go(1'b0, n, ix, d);
			rd(REG_STATUS, 32'h1c, 32'h08);
			go(1'b1, n, ix, 32'h0);
			rd(REG_RDATA, m, d & m);
			go(1'b0, 3'h0, ix, 32'h0);
			go(1'b1, 3'h1, ix, 32'h0);
			rd(REG_RDATA, 32'hff, (d >> (8 * (n - 3'h1))) & 32'hff);
		end
		deaf <= 1'b1;
		go(1'b0, 3'h1, 16'h0300, 32'h0);
		rd(REG_STATUS, 32'h0e, 32'h0e);
		deaf <= 1'b0;
		// code settles an edge ahead so the model never latches it mid-update
		code <= 8'ha5;
		@(posedge i_sys_clk);
		fire <= 1'b1;
		@(posedge i_sys_clk);
		fire <= 1'b0;
		code <= 8'h5a;
		@(posedge i_sys_clk);
		fire <= 1'b1;
		repeat (3) @(posedge i_sys_clk);
		fire <= 1'b0;
		rd(REG_STATUS, 32'h20, 32'h20);
		go(1'b1, 3'h1, RES_IDX, 32'h0);
		rd(REG_RDATA, 32'hff, 32'ha5);
		wr(REG_CTRL, 32'h1);
		rd(REG_STATUS, 32'h20, 32'h0);
		wr(REG_CTRL, 32'h3);
		go(1'b0, 3'h1, CLR_IDX, 32'h0);
		rd(REG_STATUS, 32'h20, 32'h0);
		wr(8'h20, 32'hffffffff);
		rd(8'h20, 32'hffffffff, 32'h0);
		rd(REG_CTRL, 32'h3, 32'h3);
		wr(REG_WDATA, 32'h11223344);
		wr(REG_CMD, {1'b1, 11'h0, 1'b0, 3'h4, 16'h0400});
		// power drop in mid-transfer must free both lines
		wr(REG_CTRL, 32'h0);
		repeat (4) @(posedge i_sys_clk);
		rd(REG_STATUS, 32'hc3, 32'hc0);
		chk(32'(pins.shutdown_n_pin), 32'h0);
		// let the watcher take the last note before the verdict
		@(posedge i_sys_clk);
		if (exp_q.size() != 0) begin
			err_total++;
		end
		complete_run();
	end
endmodule
`default_nettype wire

// ---- tb/tofc_sensor_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module tofc_sensor_model #(
	parameter logic [7:0] PART_ID = 8'h5a, // arbitrary value
	parameter logic [7:0] KIND_ID = 8'h3c, // arbitrary value
	parameter logic [15:0] RES_IDX = 16'h0089,
	parameter logic [15:0] CLR_IDX = 16'h0086,
	parameter realtime BOOT_NS = 1200000.0
) (
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_shutdown_n_pin,
	input wire logic i_deaf,
	input wire logic i_fire,
	input wire logic [7:0] i_code,
	output logic o_sda_pull,
	output logic o_int_n
);
	// ----
	// target side of the link
	// ----
	logic [7:0] mem [0:65535];
	logic [7:0] sh = 8'h0, tx = 8'h0;
	logic [15:0] idx = 16'h0;
	logic [3:0] bc = 4'h0;
	logic [2:0] st = 3'h0;
	logic ha = 1'b0, pend = 1'b0, pull = 1'b0;
	realtime up_at = 0.0;
	// boot starts when the shutdown pin rises; a pin tied high boots from power-up into software sleep
	always @(posedge i_shutdown_n_pin) up_at = $realtime;
	// asleep means off the bus, whatever slot it was in
	assign o_sda_pull = pull & i_shutdown_n_pin;
	assign o_int_n = pend ? 1'b0 : 1'b1;
	always @(posedge i_fire) begin
		if (!pend) begin
			pend = 1'b1;
			mem[RES_IDX] = i_code;
		end
	end
	// 1 ns wait before looking at scl so an scl fall in the same step is not taken for a start or stop
	always @(i_sda) begin
		#1;
		if (i_scl) begin
			st = (!i_sda && i_shutdown_n_pin && !i_deaf && ($realtime - up_at >= BOOT_NS)) ? 3'h1 : 3'h0;
			bc = 4'h0;
		end
	end
	always @(posedge i_scl) begin
		if (st != 3'h0) begin
			if (bc != 4'h8) begin
				sh = {sh[6:0], i_sda};
				bc = bc + 4'h1;
			end else begin
				bc = 4'h0;
				if (ha && i_sda) st = 3'h0;
				if (ha) idx = idx + 16'h1;
			end
		end
	end
	always @(negedge i_scl) begin
		pull = 1'b0;
		ha = 1'b0;
		if (st != 3'h0 && bc == 4'h8) begin
			pull = (st != 3'h5);
			ha = (st == 3'h5);
			if (st == 3'h1 && sh[7:1] != 7'h29) pull = 1'b0;
			if (st == 3'h4 && idx == CLR_IDX) pend = 1'b0;
			if (st == 3'h4) mem[idx] = sh;
			if (st == 3'h4) idx = idx + 16'h1;
			if (st == 3'h3) idx[7:0] = sh;
			if (st == 3'h2) idx[15:8] = sh;
			if (st == 3'h1) st = (sh[7:1] != 7'h29) ? 3'h0 : (sh[0] ? 3'h5 : 3'h2);
			else if (st < 3'h4) st = st + 3'h1;
		end else if (st == 3'h5) begin
			if (bc == 4'h0) tx = (idx == 16'h010f) ? PART_ID : (idx == 16'h0110) ? KIND_ID : mem[idx];
			pull = ~tx[3'h7 - bc[2:0]];
		end
	end
endmodule
`default_nettype wire
